// File: rtl/adc_ser_pkg.sv
// Purpose: shared constants and types of the result serializer
// Assumes: system clock of 10 MHz feeding every register
// Notes:   code constants are 22-bit polarity+result fields
package adc_ser_pkg;

	// system clock
	localparam int CLK_HZ         = 10_000_000;

	// word layout
	localparam int WORD_BITS      = 24;
	localparam int RESULT_BITS    = 21;
	localparam int CODE_BITS      = 22;
	localparam int BIT_PENDING    = 23;
	localparam int BIT_FILLER     = 22;
	localparam int CNT_BITS       = 5;
	localparam logic [CNT_BITS-1:0] LAST_FALL = CNT_BITS'(WORD_BITS - 1);

	// offset-binary codes: zero, clamp above +FS, clamp below -FS
	localparam logic [CODE_BITS-1:0] CODE_ZERO  = 22'h200000;
	localparam logic [CODE_BITS-1:0] CODE_OVER  = 22'h300000;
	localparam logic [CODE_BITS-1:0] CODE_UNDER = 22'h0FFFFF;
	localparam logic                 FILLER_LVL = 1'b0;

	// conversion clock
	localparam int REJ_DECIM      = 2560;
	localparam int REJ_50_HZ      = 50;
	localparam int REJ_60_HZ      = 60;
	localparam int OSC_DIV_50     = CLK_HZ / (REJ_DECIM * REJ_50_HZ);
	localparam int OSC_DIV_60     = CLK_HZ / (REJ_DECIM * REJ_60_HZ);
	localparam int OSC_BITS       = 8;
	localparam int CONV_TICKS_DEF = 20510;
	localparam int CONV_BITS      = 16;

	// serial clock made from the conversion clock
	localparam int SCK_DIV        = 8;
	localparam int SCK_HALF       = SCK_DIV / 2;
	localparam int HALF_BITS      = 3;

	// external clock detection
	localparam int EXT_MIN_HZ     = 5000;
	localparam int EXT_ABSENT_CYC = CLK_HZ / EXT_MIN_HZ;
	localparam int ABS_BITS       = 12;

	// buffering
	localparam int FIFO_DEPTH     = 16;

	typedef enum logic [1:0] {
		ST_CONVERT = 2'b00,
		ST_SLEEP   = 2'b01,
		ST_OUTPUT  = 2'b10
	} conv_state_t;

endpackage : adc_ser_pkg

// File: rtl/bit_sync.sv
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: inputs are quasi-static compared with clk
// Notes:   first stage feeds only the second stage
module bit_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// pins and synchronised copy
	input  wire logic [WIDTH-1:0] async_in,
	input  wire logic [WIDTH-1:0] reset_val,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage;

	// first stage runs through reset, so the pin level is known early
	always_ff @(posedge clk) begin
		stage <= async_in;
	end

	// idle level at reset, so no false edge follows release
	always_ff @(posedge clk) begin
		if (rst)
			sync_out <= reset_val;
		else
			sync_out <= stage;
	end

endmodule : bit_sync

// File: rtl/result_fifo.sv
// Purpose: result buffer between filter and serializer
// Assumes: single clock, registered flags
// Notes:   in_ready and out_valid come straight from flops
module result_fifo #(
	parameter int WIDTH = 23,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// filling side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// draining side
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_idx;
	logic [AW-1:0]    rd_idx;
	logic [AW:0]      count;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	assign push     = in_valid && in_ready;
	assign pop      = out_valid && out_ready;
	assign out_data = mem[rd_idx];

	always_comb begin
		next_count = count;
		if (push && !pop)
			next_count = count + 1'b1;
		else if (pop && !push)
			next_count = count - 1'b1;
	end

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_idx] <= in_data;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_idx    <= '0;
			rd_idx    <= '0;
			count     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push)
				wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
			if (pop)
				rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
			count     <= next_count;
			in_ready  <= (next_count != (AW+1)'(DEPTH));
			out_valid <= (next_count != '0);
		end
	end

endmodule : result_fifo

// File: rtl/adc_result_serializer.sv
// Purpose: result word formatting, serial shift-out, clock selection
// Assumes: pins are asynchronous to clk; filter hands over results
// Notes:   modulator and filter arithmetic live outside this block

// How it works
// [R1] every transfer carries a 24-bit word
// [R2] three status bits lead, then 21 result bits MSB first
// [R3] bit 23 is high while converting, low once done
// [R4] pending flag shows on the data pin whenever chip select is low
// [R5] bit 22 is a filler, always low
// [R6] polarity bit high for positive or zero input, low for negative
// [R7] polarity and MSB both high means over, both low means under
// [R8] bits 20 to 0 hold the result, bit 0 least significant
// [R9] chip select high: data pin released, clock edges ignored
// [R10] host lowers chip select first; may use the falling flag as IRQ
// [R11] bit 23 valid at first rise; bit 22 goes out on first fall
// [R12] bit 0 goes out on fall 23, host latches it on rise 24
// [R13] fall 24 drives the data line high, new conversion begins
// [R14] offset binary: zero is 1 then zeros, minus one LSB 0 then ones
// [R15] out-of-range inputs clamp to plus FS+1LSB or minus FS-1LSB
// [R16] select pin low picks 60 Hz, high picks 50 Hz rejection
// [R17] select changes take effect at the next conversion start
// [R18] clock on the select pin is detected, internal oscillator stops
// [R19] external rejection frequency is the clock divided by 2560
// [R20] lost external clock restarts oscillator, sparing other states
// [R21] source change in internal serial clock mode keeps data correct
// [R22] output ends after 24 bits or chip select high; then convert
// [R23] chip select fall and power-up pick serial clock mode from pin
// [R24] internal serial clock is the conversion clock divided by 8
// [R25] external clock declared absent after a fixed idle count
// [R26] pins are synchronised before any edge detection
module adc_result_serializer
	import adc_ser_pkg::*;
#(
	parameter int CONV_TICKS     = CONV_TICKS_DEF,
	parameter int EXT_ABSENT     = EXT_ABSENT_CYC,
	parameter int FIFO_WORDS     = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// results from the filter
	input  wire logic [RESULT_BITS-1:0] res_value,
	input  wire logic                   res_over,
	input  wire logic                   res_under,
	input  wire logic                   res_valid,
	output logic                        res_ready,
	// serial link pins
	input  wire logic                   cs_n,
	input  wire logic                   sck_in,
	output logic                        sck_out,
	output logic                        sck_oe_n,
	output logic                        sdo_out,
	output logic                        sdo_oe_n,
	// frequency select pin
	input  wire logic                   rejection_select_pin,
	// status toward the filter
	output logic                        conv_tick,
	output logic                        ext_clock_active,
	output logic                        reject_50hz,
	output logic                        conv_pending
);

	localparam int FW = RESULT_BITS + 2;

	// synchronised pins
	logic              cs_s;
	logic              sck_s;
	logic              f0_s;
	logic              cs_prev;
	logic              sck_prev;
	logic              f0_prev;
	logic              cs_fall;
	logic              cs_rise;
	logic              f0_rise;

	// clocking
	logic [OSC_BITS-1:0] osc_cnt;
	logic [OSC_BITS-1:0] osc_top;
	logic                osc_tick;
	logic                tick;
	logic [ABS_BITS-1:0] abs_cnt;

	// serial clock
	logic                 boot;
	logic                 boot_wait;
	logic                 int_mode;
	logic                 int_run;
	logic [HALF_BITS-1:0] half_cnt;
	logic                 int_rise;
	logic                 int_fall;
	logic                 rise_ev;
	logic                 fall_ev;

	// state and data
	conv_state_t           state;
	logic [CONV_BITS-1:0]  conv_cnt;
	logic                  conv_done;
	logic [WORD_BITS-1:0]  shreg;
	logic [CNT_BITS-1:0]   fall_cnt;
	logic                  sel50;
	logic [FW-1:0]         fifo_out;
	logic                  fifo_valid;
	logic                  fifo_pop;
	logic [CODE_BITS-1:0]  code;

	// [R26] pins synchronised first
	bit_sync #(
		.WIDTH (3)
	) u_pin_sync (
		.clk       (clk),
		.rst       (rst),
		.async_in  ({cs_n, sck_in, rejection_select_pin}),
		// select and clock idle high, select pin idle low
		// a high select pin only restarts the absence timer once
		.reset_val (3'h6),
		.sync_out  ({cs_s, sck_s, f0_s})
	);

	// buffer lets the filter run ahead of a slow host
	result_fifo #(
		.WIDTH (FW),
		.DEPTH (FIFO_WORDS)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_data   ({res_over, res_under, res_value}),
		.in_valid  (res_valid),
		.in_ready  (res_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			cs_prev  <= 1'b1;
			sck_prev <= 1'b1;
			f0_prev  <= 1'b0;
		end else begin
			cs_prev  <= cs_s;
			sck_prev <= sck_s;
			f0_prev  <= f0_s;
		end
	end

	assign cs_fall = cs_prev && !cs_s;
	assign cs_rise = !cs_prev && cs_s;
	assign f0_rise = f0_s && !f0_prev;

	// [R25] absence timer, one edge alone is a level change
	// [R18] second edge inside the window means a clock
	always_ff @(posedge clk) begin
		if (rst) begin
			abs_cnt          <= ABS_BITS'(EXT_ABSENT);
			ext_clock_active <= 1'b0;
		end else if (f0_rise) begin
			if (abs_cnt < ABS_BITS'(EXT_ABSENT))
				ext_clock_active <= 1'b1;
			abs_cnt <= '0;
		end else if (abs_cnt < ABS_BITS'(EXT_ABSENT)) begin
			abs_cnt <= abs_cnt + 1'b1;
		end else begin
			// [R20] clock gone, oscillator back
			ext_clock_active <= 1'b0;
		end
	end

	// [R16] low pin gives 60 Hz, high gives 50 Hz
	assign osc_top = sel50 ? OSC_BITS'(OSC_DIV_50 - 1)
	                       : OSC_BITS'(OSC_DIV_60 - 1);
	assign osc_tick = (osc_cnt >= osc_top);

	// oscillator held still while the pin clocks the converter
	always_ff @(posedge clk) begin
		if (rst || ext_clock_active || osc_tick)
			osc_cnt <= '0;
		else
			osc_cnt <= osc_cnt + 1'b1;
	end

	// [R19] filter decimates the external clock by the fixed ratio
	assign tick = ext_clock_active ? f0_rise : osc_tick;

	always_ff @(posedge clk) begin
		if (rst) begin
			conv_tick   <= 1'b0;
			reject_50hz <= 1'b0;
		end else begin
			conv_tick   <= tick;
			reject_50hz <= sel50;
		end
	end

	// [R23] mode taken right after reset and at each select fall
	// boot lasts two cycles: the first still sees the reset level
	// of the synchroniser, the second sees the real pin
	always_ff @(posedge clk) begin
		if (rst) begin
			boot_wait <= 1'b1;
			boot      <= 1'b1;
			int_mode  <= 1'b1;
		end else begin
			boot_wait <= 1'b0;
			boot      <= boot_wait;
			if (boot || cs_fall)
				int_mode <= sck_s;
		end
	end

	// driving starts only after the pin level was taken
	assign int_run = int_mode && !cs_s && !cs_fall && !boot
	                 && (state != ST_CONVERT);

	// [R24] half period of four conversion ticks
	// [R21] a source change only stretches a half period
	always_ff @(posedge clk) begin
		if (rst || !int_run) begin
			half_cnt <= '0;
			sck_out  <= 1'b0;
			int_rise <= 1'b0;
			int_fall <= 1'b0;
		end else begin
			int_rise <= 1'b0;
			int_fall <= 1'b0;
			if (tick) begin
				if (half_cnt == HALF_BITS'(SCK_HALF - 1)) begin
					half_cnt <= '0;
					sck_out  <= !sck_out;
					int_rise <= !sck_out;
					int_fall <= sck_out;
				end else begin
					half_cnt <= half_cnt + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			sck_oe_n <= 1'b1;
		else
			sck_oe_n <= !int_run;
	end

	// [R9] edges count only while chip select is low
	assign rise_ev = !cs_s && (int_mode ? int_rise : (sck_s && !sck_prev));
	assign fall_ev = !cs_s && (int_mode ? int_fall : (!sck_s && sck_prev));

	// [R14] offset binary by adding half scale
	// [R15] range clamps
	// [R7] clamps leave polarity and MSB equal
	always_comb begin
		if (fifo_out[FW-1])
			code = CODE_OVER;
		else if (fifo_out[FW-2])
			code = CODE_UNDER;
		else
			code = CODE_BITS'({fifo_out[RESULT_BITS-1],
			                   fifo_out[RESULT_BITS-1:0]}) + CODE_ZERO;
	end

	// late result keeps the flag high rather than sending stale data
	assign conv_done = (conv_cnt >= CONV_BITS'(CONV_TICKS));
	assign fifo_pop  = (state == ST_CONVERT) && conv_done;

	always_ff @(posedge clk) begin
		if (rst) begin
			state    <= ST_CONVERT;
			conv_cnt <= '0;
			sel50    <= 1'b0;
			shreg    <= '0;
			fall_cnt <= '0;
		end else begin
			unique case (state)
				ST_CONVERT: begin
					if (tick && !conv_done)
						conv_cnt <= conv_cnt + 1'b1;
					// result waits in the buffer if late
					if (conv_done && fifo_valid) begin
						// [R1] [R2] [R5] [R6] [R8]
						shreg <= {1'b0, FILLER_LVL, code};
						state <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					// [R11] first rise opens the transfer
					fall_cnt <= '0;
					if (rise_ev)
						state <= ST_OUTPUT;
				end
				ST_OUTPUT: begin
					if (cs_rise) begin
						// [R22] aborted transfer restarts conversion
						state    <= ST_CONVERT;
						conv_cnt <= '0;
						sel50    <= f0_s;
					end else if (fall_ev) begin
						fall_cnt <= fall_cnt + 1'b1;
						if (fall_cnt == LAST_FALL) begin
							// [R13] twenty-fourth fall starts converting
							state    <= ST_CONVERT;
							conv_cnt <= '0;
							// [R17] selection latched per conversion
							sel50    <= f0_s;
						end else begin
							// [R11] [R12] one bit per fall
							shreg <= {shreg[WORD_BITS-2:0], 1'b0};
						end
					end
				end
				default: begin
					state <= ST_CONVERT;
				end
			endcase
		end
	end

	// [R3] [R4] pending high in conversion, word msb otherwise
	always_ff @(posedge clk) begin
		if (rst) begin
			sdo_out      <= 1'b1;
			sdo_oe_n     <= 1'b1;
			conv_pending <= 1'b1;
		end else begin
			sdo_out      <= (state == ST_CONVERT) ? 1'b1
			                                      : shreg[BIT_PENDING];
			// [R9] released while chip select high
			sdo_oe_n     <= cs_s;
			conv_pending <= (state == ST_CONVERT);
		end
	end

endmodule : adc_result_serializer

// File: testbench/adc_result_serializer_monitor.sv
// Purpose: port assertions of the result serializer
// Assumes: one clock, synchronous active-high reset
// Notes:   pin latencies include the two-flop synchronisers
module adc_ser_checker (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// watched ports
	input wire logic res_valid,
	input wire logic res_ready,
	input wire logic cs_n,
	input wire logic sck_oe_n,
	input wire logic sdo_out,
	input wire logic sdo_oe_n,
	input wire logic conv_tick,
	input wire logic ext_clock_active,
	input wire logic reject_50hz,
	input wire logic conv_pending
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);

	property p_sdo_release; cs_n [*4] |-> sdo_oe_n; endproperty
	a_sdo_release: assert property (p_sdo_release)
		else $error("data pin driven while deselected");
	property p_sdo_drive; !cs_n [*4] |-> !sdo_oe_n; endproperty
	a_sdo_drive: assert property (p_sdo_drive)
		else $error("data pin not driven while selected");
	property p_flag_high;
		conv_pending [*3] ##0 !sdo_oe_n |-> sdo_out;
	endproperty
	a_flag_high: assert property (p_flag_high)
		else $error("flag low while converting");
	property p_flag_fall;
		$fell(conv_pending) && !sdo_oe_n |-> ##[0:2] !sdo_out;
	endproperty
	a_flag_fall: assert property (p_flag_fall)
		else $error("flag did not fall at completion");
	property p_ready_push;
		$fell(res_ready) |-> $past(res_valid) || $past(res_valid, 2);
	endproperty
	a_ready_push: assert property (p_ready_push)
		else $error("buffer filled without a push");
	property p_tick_gap;
		conv_tick && !ext_clock_active |=> !conv_tick [*8];
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("oscillator ticks too close");
	property p_sel_hold; !conv_pending |-> $stable(reject_50hz); endproperty
	a_sel_hold: assert property (p_sel_hold)
		else $error("selection changed outside conversion");
	property p_sck_off; cs_n [*4] |-> sck_oe_n; endproperty
	a_sck_off: assert property (p_sck_off)
		else $error("clock pin driven while deselected");

	c_done: cover property ($fell(conv_pending));
	c_full: cover property ($fell(res_ready));
	c_ext: cover property ($rose(ext_clock_active));
	c_int_clock: cover property ($fell(sck_oe_n));
endmodule : adc_ser_checker

bind adc_result_serializer adc_ser_checker i_adc_ser_checker (.clk, .rst,
	.res_valid, .res_ready, .cs_n, .sck_oe_n, .sdo_out, .sdo_oe_n,
	.conv_tick, .ext_clock_active, .reject_50hz, .conv_pending);

// File: testbench/spi_host_model.sv
// Purpose: host side of the serial link, reading result words
// Assumes: clock line level at select fall picks the clock mode
// Notes:   8 clk half periods, above the 4 clk minimum
module spi_host_model
	import adc_ser_pkg::*;
(
	// clock
	input  wire logic clk,
	// serial link
	output logic      cs_n,
	output logic      sck,
	input  wire logic sck_line,
	input  wire logic sdo_out,
	input  wire logic sdo_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last = 1'b0;
	logic sdo;

	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
	end
	// released pin floats: show the inverse of the last level
	always @(posedge clk)
		if (!sdo_oe_n)
			last <= sdo_out;
	assign sdo = sdo_oe_n ? ~last : sdo_out;

	task automatic read_word(input int nbits,
		output logic [WORD_BITS-1:0] w, output logic endb);
		int n;
		w = '0;
		@(posedge clk);
		cs_n <= 1'b0;
		for (n = 0; n < 4000 && !(n > 4 && sdo === 1'b0); n++)
			@(posedge clk);
		for (n = 0; n < nbits; n++) begin
			repeat (8) @(posedge clk);
			w = {w[WORD_BITS-2:0], sdo};
			sck <= 1'b1;
			repeat (8) @(posedge clk);
			sck <= 1'b0;
		end
		repeat (8) @(posedge clk);
		endb = sdo;
		cs_n <= 1'b1;
		// long enough high for the synchroniser
		repeat (4) @(posedge clk);
	endtask : read_word

	// device drives the line; one bit taken at each of its rises
	task automatic read_word_int(output logic [WORD_BITS-1:0] w,
		output int period, output logic endb);
		int n;
		int got;
		int first;
		logic prev;
		w = '0;
		got = 0;
		first = 0;
		period = 0;
		// host holds the line high, so no false rise at the start
		prev = 1'b1;
		@(posedge clk);
		sck <= 1'b1;
		repeat (4) @(posedge clk);
		cs_n <= 1'b0;
		for (n = 0; n < 20000 && got < WORD_BITS; n++) begin
			@(posedge clk);
			if (sck_line && !prev) begin
				w = {w[WORD_BITS-2:0], sdo};
				got++;
				if (got == 1)
					first = n;
				if (got == 2)
					period = n - first;
			end
			prev = sck_line;
		end
		// last fall comes half a period after the last rise
		repeat (300) @(posedge clk);
		endb = sdo;
		cs_n <= 1'b1;
		sck  <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : read_word_int
endmodule : spi_host_model

// File: testbench/tb_adc_result_serializer.sv
// Purpose: self-checking bench of the result serializer
// Assumes: host model reads in both serial clock modes
// Notes:   conversion and idle counts shortened for run time
module tb_adc_result_serializer
	import adc_ser_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TICKS  = 20;
	localparam int ABSENT = 50;
	typedef struct packed {
		logic [RESULT_BITS-1:0] v;
		logic                   o;
		logic                   u;
		logic [CODE_BITS-1:0]   c;
	} row_t;
	row_t rows [8] = '{
		'{21'h000000, 1'b0, 1'b0, 22'h200000},
		'{21'h1FFFFF, 1'b0, 1'b0, 22'h1FFFFF},
		'{21'h0FFFFF, 1'b0, 1'b0, 22'h2FFFFF},
		'{21'h100000, 1'b0, 1'b0, 22'h100000},
		'{21'h080000, 1'b0, 1'b0, 22'h280000},
		'{21'h000000, 1'b1, 1'b0, 22'h300000},
		'{21'h000000, 1'b0, 1'b1, 22'h0FFFFF},
		'{21'h000000, 1'b1, 1'b1, 22'h300000}};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [RESULT_BITS-1:0] res_value;
	logic res_over, res_under, res_valid, res_ready, endb;
	logic cs_n, host_sck, sck_in, sck_out, sck_oe_n, sdo_out, sdo_oe_n;
	logic rejection_select_pin, conv_tick, ext_clock_active;
	logic reject_50hz, conv_pending;
	logic [WORD_BITS-1:0] w;
	int n_mismatch = 0;
	int check_count = 0;
	int cycles = 0;
	int per = 0;

	always #50 clk = ~clk;
	assign sck_in = sck_oe_n ? host_sck : sck_out;

	adc_result_serializer #(.CONV_TICKS(TICKS), .EXT_ABSENT(ABSENT))
	i_adc_result_serializer (.clk, .rst, .res_value, .res_over,
		.res_under, .res_valid, .res_ready, .cs_n, .sck_in, .sck_out,
		.sck_oe_n, .sdo_out, .sdo_oe_n, .rejection_select_pin,
		.conv_tick, .ext_clock_active, .reject_50hz, .conv_pending);
	spi_host_model i_spi_host_model (.clk, .cs_n, .sck(host_sck),
		.sck_line(sck_in), .sdo_out, .sdo_oe_n);

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	task automatic check(input string what,
		input logic [WORD_BITS-1:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic push(input logic [RESULT_BITS-1:0] v, input logic o, u);
		@(posedge clk);
		res_value <= v;
		res_over  <= o;
		res_under <= u;
		res_valid <= 1'b1;
		@(posedge clk);
		while (res_ready !== 1'b1)
			@(posedge clk);
		res_valid <= 1'b0;
	endtask : push

	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	initial begin
		res_value = '0;
		res_over = 1'b0;
		res_under = 1'b0;
		res_valid = 1'b0;
		rejection_select_pin = 1'b0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("ready", res_ready, 1'b1);
		check("oe", sdo_oe_n, 1'b1);
		check("pend", conv_pending, 1'b1);
		for (int i = 0; i < 8; i++) begin
			push(rows[i].v, rows[i].o, rows[i].u);
			i_spi_host_model.read_word(24, w, endb);
			check("word", w, {1'b0, FILLER_LVL, rows[i].c});
			check("end", endb, 1'b1);
		end
		// device-driven clock, 60 Hz rejection still selected
		push(21'h0ABCDE, 1'b0, 1'b0);
		i_spi_host_model.read_word_int(w, per, endb);
		check("int word", w, 24'h2ABCDE);
		check("period", WORD_BITS'(per), WORD_BITS'(SCK_DIV * OSC_DIV_60));
		check("int end", endb, 1'b1);
		check("sck oe", sck_oe_n, 1'b1);
		// abort after five bits
		push(21'h000123, 1'b0, 1'b0);
		i_spi_host_model.read_word(5, w, endb);
		// select rise needs sync, detect and a state update
		repeat (2) @(posedge clk);
		check("head", w[4:0], 5'b00100);
		check("abort", conv_pending, 1'b1);
		check("oe", sdo_oe_n, 1'b1);
		rejection_select_pin <= 1'b1;
		push(21'h000001, 1'b0, 1'b0);
		i_spi_host_model.read_word(24, w, endb);
		check("word", w, 24'h200001);
		repeat (8) @(posedge clk);
		check("sel", reject_50hz, 1'b1);
		repeat (30) begin
			repeat (10) @(posedge clk);
			rejection_select_pin <= ~rejection_select_pin;
		end
		check("ext", ext_clock_active, 1'b1);
		repeat (ABSENT + 10) @(posedge clk);
		check("ext", ext_clock_active, 1'b0);
		// hold one word in sleep, then fill the buffer
		push(21'h000000, 1'b0, 1'b0);
		for (int n = 0; n < 4000 && conv_pending !== 1'b0; n++)
			@(posedge clk);
		for (int i = 1; i <= FIFO_DEPTH; i++)
			push(RESULT_BITS'(i), 1'b0, 1'b0);
		repeat (2) @(posedge clk);
		check("full", res_ready, 1'b0);
		for (int i = 0; i <= FIFO_DEPTH; i++) begin
			i_spi_host_model.read_word(24, w, endb);
			check("fifo", w,
				{1'b0, FILLER_LVL, CODE_ZERO + CODE_BITS'(i)});
		end
		// reset in mid-run: back to converting at 60 Hz
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("pend", conv_pending, 1'b1);
		check("sel", reject_50hz, 1'b0);
		check("ext", ext_clock_active, 1'b0);
		check("oe", sdo_oe_n, 1'b1);
		check("ready", res_ready, 1'b1);
		wrap_up();
	end
endmodule : tb_adc_result_serializer
